// *** verilog/pbr_pkg.sv ***
// Shared constants and types for the bridge arbitration, parking and system-error block
package pbr_pkg;
  localparam int AD_W   = 32;
  localparam int CBE_W  = 4;
  localparam logic [AD_W-1:0]  PARK_AD  = 32'h0000_0000;
  localparam logic [CBE_W-1:0] PARK_CBE = 4'h0;

  // Pin synchroniser lanes, all active low, idle high
  localparam int SYNC_W    = 7;
  localparam int SY_P_GNT  = 0;
  localparam int SY_P_FRM  = 1;
  localparam int SY_P_IRDY = 2;
  localparam int SY_S_GNT  = 3;
  localparam int SY_S_FRM  = 4;
  localparam int SY_S_IRDY = 5;
  localparam int SY_S_SERR = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h7f;

  // System-error causes
  localparam int SE_W       = 9;
  localparam int SE_APAR    = 0;
  localparam int SE_PWPAR   = 1;
  localparam int SE_SSERR   = 2;
  localparam int SE_PW_MABT = 3;
  localparam int SE_PW_TABT = 4;
  localparam int SE_PW_DISC = 5;
  localparam int SE_DW_DISC = 6;
  localparam int SE_DR_DISC = 7;
  localparam int SE_DT_TMO  = 8;

  typedef enum logic [1:0] {
    PR_IDLE = 2'b00,
    PR_REQ  = 2'b01,
    PR_BUSY = 2'b10
  } pbr_preq_e;
endpackage : pbr_pkg

// *** verilog/pbr_sync3.sv ***
// Three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/1ns
module pbr_sync3
  import pbr_pkg::*;
#(
  parameter int              W   = SYNC_W,
  parameter logic [W-1:0]    RST = SYNC_RST
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r, s2_r, s3_r, dout_r;
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, dout_nxt;

  always_comb begin
    s1_nxt   = din;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    dout_nxt = dout_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        dout_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r   <= RST;
      s2_r   <= RST;
      s3_r   <= RST;
      dout_r <= RST;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;
endmodule : pbr_sync3

// *** verilog/pbr_bridge_arb.sv ***
// Primary request/grant, bus parking, system-error drive and secondary AD ownership
`timescale 1ns/1ns
// Notes on behaviour
// - System-error line is shared open drain; we only pull low or release.
// - Pull system error on address parity or posted-write data parity errors.
// - Pull primary system error when secondary system error is asserted.
// - Pull system error when a forwarded posted write master- or target-aborts.
// - Pull system error when a posted write or delayed request is discarded.
// - Pull system error when a delayed transaction hits its master timeout.
// - Assert primary request while a primary transaction is pending and not yet started.
// - Start a primary transaction only with grant asserted and bus idle.
// - Granted without request: park primary AD, command/enables and parity.
// - Initiator drives the address on secondary AD in the address phase.
// - Initiator drives write data, target drives read data in data phases.
// - Secondary idle with our grant: park secondary AD at valid levels.
// - Parked secondary parity is even over AD and CBE, one cycle later.
module pbr_bridge_arb
  import pbr_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Primary bus pins
  input  wire logic              p_gnt_l,
  input  wire logic              p_frame_l,
  input  wire logic              p_irdy_l,
  output logic                   p_req_l_o,
  output logic                   p_req_l_oe,
  output logic                   p_serr_l_o,
  output logic                   p_serr_l_oe,
  output logic [AD_W-1:0]        p_ad_o,
  output logic                   p_ad_oe,
  output logic [CBE_W-1:0]       p_cbe_l_o,
  output logic                   p_cbe_l_oe,
  output logic                   p_par_o,
  output logic                   p_par_oe,
  // Secondary bus pins
  input  wire logic              s_gnt_l,
  input  wire logic              s_frame_l,
  input  wire logic              s_irdy_l,
  input  wire logic              s_serr_l,
  output logic [AD_W-1:0]        s_ad_o,
  output logic                   s_ad_oe,
  output logic [CBE_W-1:0]       s_cbe_l_o,
  output logic                   s_cbe_l_oe,
  output logic                   s_par_o,
  output logic                   s_par_oe,
  // Bridge core, primary master side
  input  wire logic              p_xfer_pending,
  input  wire logic              p_xfer_done,
  output logic                   p_xfer_start,
  // Bridge core, error events and cause enables
  input  wire logic              ev_addr_par,
  input  wire logic              ev_pw_data_par,
  input  wire logic              ev_pw_mabort,
  input  wire logic              ev_pw_tabort,
  input  wire logic              ev_pw_discard,
  input  wire logic              ev_dw_discard,
  input  wire logic              ev_dr_discard,
  input  wire logic              ev_dt_timeout,
  input  wire logic [SE_W-1:0]   serr_cause_en,
  // Bridge core, secondary phase ownership
  input  wire logic              s_mst_addr_ph,
  input  wire logic              s_mst_wr_ph,
  input  wire logic              s_mst_rd_ph,
  input  wire logic              s_tgt_rd_ph,
  input  wire logic [AD_W-1:0]   s_mst_addr,
  input  wire logic [AD_W-1:0]   s_mst_wdata,
  input  wire logic [CBE_W-1:0]  s_mst_cbe_l,
  input  wire logic [AD_W-1:0]   s_tgt_rdata
);
  logic [SYNC_W-1:0] pin_q;
  logic p_gnt_q, p_idle_q, s_gnt_q, s_idle_q, s_serr_q;
  pbr_sync3 #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({s_serr_l, s_irdy_l, s_frame_l, s_gnt_l, p_irdy_l, p_frame_l, p_gnt_l}),
    .dout    (pin_q)
  );
  assign p_gnt_q  = !pin_q[SY_P_GNT];
  assign p_idle_q = pin_q[SY_P_FRM] && pin_q[SY_P_IRDY];
  assign s_gnt_q  = !pin_q[SY_S_GNT];
  assign s_idle_q = pin_q[SY_S_FRM] && pin_q[SY_S_IRDY];
  assign s_serr_q = !pin_q[SY_S_SERR];
  // Primary request state
  pbr_preq_e st_r, st_nxt;
  logic      req_r, req_nxt, start_r, start_nxt, req_oe_r;
  logic      p_park_cond;
  always_comb begin
    st_nxt    = st_r;
    start_nxt = 1'b0;
    case (st_r)
      PR_IDLE: begin
        if (p_xfer_pending) begin
          st_nxt = PR_REQ;
        end
      end
      PR_REQ: begin
        if (p_gnt_q && p_idle_q) begin
          st_nxt    = PR_BUSY;
          start_nxt = 1'b1;
        end
      end
      PR_BUSY: begin
        if (p_xfer_done) begin
          st_nxt = PR_IDLE;
        end
      end
      default: st_nxt = PR_IDLE;
    endcase
    req_nxt = (st_nxt == PR_REQ);
  end

  // Parking only when no request is out and none is about to be raised
  assign p_park_cond = p_gnt_q && (st_r == PR_IDLE) && !p_xfer_pending;
  logic            p_park_r, p_park_nxt, p_par_oe_r;
  logic            p_par_r, p_par_nxt;
  always_comb begin
    p_park_nxt = p_park_cond;
    p_par_nxt  = ^{PARK_AD, PARK_CBE};
  end
  // System-error causes, one gate per cause
  logic [SE_W-1:0] se_cause, se_hit;
  logic            serr_r, serr_nxt;
  assign se_cause[SE_APAR]    = ev_addr_par;
  assign se_cause[SE_PWPAR]   = ev_pw_data_par;
  assign se_cause[SE_SSERR]   = s_serr_q;
  assign se_cause[SE_PW_MABT] = ev_pw_mabort;
  assign se_cause[SE_PW_TABT] = ev_pw_tabort;
  assign se_cause[SE_PW_DISC] = ev_pw_discard;
  assign se_cause[SE_DW_DISC] = ev_dw_discard;
  assign se_cause[SE_DR_DISC] = ev_dr_discard;
  assign se_cause[SE_DT_TMO]  = ev_dt_timeout;
  for (genvar g = 0; g < SE_W; g++) begin : g_se
    assign se_hit[g] = se_cause[g] && serr_cause_en[g];
  end

  // Held low as long as any enabled cause stands; the pull-up restores high
  always_comb begin
    serr_nxt = |se_hit;
  end
  // Secondary AD ownership; if the core overlaps phases, address wins, then master write, master read, target read, parking
  logic [AD_W-1:0]  s_ad_r, s_ad_nxt;
  logic [CBE_W-1:0] s_cbe_r, s_cbe_nxt;
  logic             s_ad_oe_r, s_ad_oe_nxt, s_cbe_oe_r, s_cbe_oe_nxt;
  logic             s_par_r, s_par_nxt, s_par_oe_r, s_par_oe_nxt;
  logic             s_park_cond;

  assign s_park_cond = s_gnt_q && s_idle_q;
  always_comb begin
    s_ad_nxt     = PARK_AD;
    s_cbe_nxt    = PARK_CBE;
    s_ad_oe_nxt  = 1'b0;
    s_cbe_oe_nxt = 1'b0;
    if (s_mst_addr_ph) begin
      s_ad_nxt     = s_mst_addr;
      s_cbe_nxt    = s_mst_cbe_l;
      s_ad_oe_nxt  = 1'b1;
      s_cbe_oe_nxt = 1'b1;
    end else if (s_mst_wr_ph) begin
      s_ad_nxt     = s_mst_wdata;
      s_cbe_nxt    = s_mst_cbe_l;
      s_ad_oe_nxt  = 1'b1;
      s_cbe_oe_nxt = 1'b1;
    end else if (s_mst_rd_ph) begin
      s_cbe_nxt    = s_mst_cbe_l;
      s_cbe_oe_nxt = 1'b1;
    end else if (s_tgt_rd_ph) begin
      s_ad_nxt     = s_tgt_rdata;
      s_ad_oe_nxt  = 1'b1;
    end else if (s_park_cond) begin
      s_ad_oe_nxt  = 1'b1;
      s_cbe_oe_nxt = 1'b1;
    end
    // Parity trails whatever AD carried one cycle earlier
    s_par_nxt    = ^{s_ad_r, s_cbe_r};
    s_par_oe_nxt = s_ad_oe_r;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r       <= PR_IDLE;
      req_r      <= 1'b0;
      req_oe_r   <= 1'b0;
      start_r    <= 1'b0;
      p_park_r   <= 1'b0;
      p_par_r    <= 1'b0;
      p_par_oe_r <= 1'b0;
      serr_r     <= 1'b0;
      s_ad_r     <= PARK_AD;
      s_cbe_r    <= PARK_CBE;
      s_ad_oe_r  <= 1'b0;
      s_cbe_oe_r <= 1'b0;
      s_par_r    <= 1'b0;
      s_par_oe_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      req_r      <= req_nxt;
      req_oe_r   <= 1'b1;
      start_r    <= start_nxt;
      p_park_r   <= p_park_nxt;
      p_par_r    <= p_par_nxt;
      p_par_oe_r <= p_park_r;
      serr_r     <= serr_nxt;
      s_ad_r     <= s_ad_nxt;
      s_cbe_r    <= s_cbe_nxt;
      s_ad_oe_r  <= s_ad_oe_nxt;
      s_cbe_oe_r <= s_cbe_oe_nxt;
      s_par_r    <= s_par_nxt;
      s_par_oe_r <= s_par_oe_nxt;
    end
  end

  assign p_req_l_o    = !req_r;
  assign p_req_l_oe   = req_oe_r;
  assign p_xfer_start = start_r;
  // Data lane of the open-drain pin is tied constant low; only the enable moves
  assign p_serr_l_o   = 1'b0;
  assign p_serr_l_oe  = serr_r;
  assign p_ad_o       = PARK_AD;
  assign p_ad_oe      = p_park_r;
  assign p_cbe_l_o    = PARK_CBE;
  assign p_cbe_l_oe   = p_park_r;
  assign p_par_o      = p_par_r;
  assign p_par_oe     = p_par_oe_r;
  assign s_ad_o       = s_ad_r;
  assign s_ad_oe      = s_ad_oe_r;
  assign s_cbe_l_o    = s_cbe_r;
  assign s_cbe_l_oe   = s_cbe_oe_r;
  assign s_par_o      = s_par_r;
  assign s_par_oe     = s_par_oe_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence q_park_lines;
    p_ad_oe && p_cbe_l_oe && (p_ad_o == PARK_AD) && (p_cbe_l_o == PARK_CBE);
  endsequence
  property p_serr_od;
    p_serr_l_oe |-> !p_serr_l_o;
  endproperty
  a_serr_od: assert property (p_serr_od) else $error("serr driven high");
  property p_serr_apar;
    (ev_addr_par && serr_cause_en[SE_APAR]) |=> p_serr_l_oe;
  endproperty
  a_serr_apar: assert property (p_serr_apar) else $error("no serr on addr parity");
  property p_serr_sec;
    (s_serr_q && serr_cause_en[SE_SSERR]) |=> p_serr_l_oe;
  endproperty
  a_serr_sec: assert property (p_serr_sec) else $error("no serr on secondary serr");
  property p_serr_abort;
    ((ev_pw_mabort && serr_cause_en[SE_PW_MABT]) ||
     (ev_pw_tabort && serr_cause_en[SE_PW_TABT])) |=> p_serr_l_oe;
  endproperty
  a_serr_abort: assert property (p_serr_abort) else $error("no serr on abort");
  property p_serr_disc;
    (ev_dr_discard && serr_cause_en[SE_DR_DISC]) |=> p_serr_l_oe;
  endproperty
  a_serr_disc: assert property (p_serr_disc) else $error("no serr on discard");
  property p_serr_quiet;
    (!(|(se_cause & serr_cause_en))) |=> !p_serr_l_oe;
  endproperty
  a_serr_quiet: assert property (p_serr_quiet) else $error("serr without cause");
  property p_req_raise;
    (st_r == PR_IDLE && p_xfer_pending) |=> !p_req_l_o;
  endproperty
  a_req_raise: assert property (p_req_raise) else $error("request not raised");
  property p_start_ok;
    p_xfer_start |-> ($past(p_gnt_q) && $past(p_idle_q) && !$past(p_req_l_o));
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("start without grant or idle");
  property p_park_pri;
    p_park_cond |=> q_park_lines ##1 (p_par_oe && (p_par_o == ^{PARK_AD, PARK_CBE}));
  endproperty
  a_park_pri: assert property (p_park_pri) else $error("primary not parked");
  property p_sec_addr;
    s_mst_addr_ph |=> (s_ad_oe && s_ad_o == $past(s_mst_addr));
  endproperty
  a_sec_addr: assert property (p_sec_addr) else $error("address not driven");
  property p_sec_rd;
    (s_tgt_rd_ph && !s_mst_addr_ph && !s_mst_wr_ph && !s_mst_rd_ph)
      |=> (s_ad_oe && s_ad_o == $past(s_tgt_rdata));
  endproperty
  a_sec_rd: assert property (p_sec_rd) else $error("read data not driven");
  property p_sec_park;
    (s_park_cond && !s_mst_addr_ph && !s_mst_wr_ph && !s_mst_rd_ph && !s_tgt_rd_ph)
      |=> (s_ad_oe && s_ad_o == PARK_AD) ##1 (s_par_oe && s_par_o == ^{PARK_AD, PARK_CBE});
  endproperty
  a_sec_park: assert property (p_sec_park) else $error("secondary not parked");
  property p_sec_par;
    s_ad_oe |=> (s_par_oe && s_par_o == ^{$past(s_ad_o), $past(s_cbe_l_o)});
  endproperty
  a_sec_par: assert property (p_sec_par) else $error("bad secondary parity");
  property p_req_hold;
    (st_r == PR_REQ && !(p_gnt_q && p_idle_q)) |=> !p_req_l_o;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
endmodule : pbr_bridge_arb

// *** dv/pbr_bus_model.sv ***
// Primary arbiter plus a competing agent that keeps the primary bus busy
`timescale 1ns/1ns
module pbr_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       p_req_l,
  input  wire logic       park_gnt,
  input  wire logic [3:0] gnt_delay,
  input  wire logic [3:0] busy_cyc,
  output logic            p_gnt_l,
  output logic            p_frame_l,
  output logic            p_irdy_l
);
  logic [3:0] wait_r;
  logic [3:0] busy_r;
  logic       seen_r;

  // Another master may still own the bus when our grant arrives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p_gnt_l   <= 1'b1;
      p_frame_l <= 1'b1;
      p_irdy_l  <= 1'b1;
      wait_r    <= 4'h0;
      busy_r    <= 4'h0;
      seen_r    <= 1'b0;
    end else begin
      p_irdy_l <= p_frame_l;
      if (!p_req_l && !seen_r) begin
        seen_r <= 1'b1;
        wait_r <= gnt_delay;
        busy_r <= busy_cyc;
      end else if (p_req_l) begin
        seen_r <= 1'b0;
      end
      if (busy_r != 4'h0) begin
        busy_r    <= busy_r - 4'h1;
        p_frame_l <= 1'b0;
      end else begin
        p_frame_l <= 1'b1;
      end
      if (seen_r && !p_req_l) begin
        if (wait_r != 4'h0) begin
          wait_r <= wait_r - 4'h1;
        end else begin
          p_gnt_l <= 1'b0;
        end
      end else begin
        p_gnt_l <= !park_gnt;
      end
    end
  end
endmodule : pbr_bus_model

// *** dv/pbr_bridge_arb_bench.sv ***
// Self-checking bench for request/grant, parking, system error and secondary AD
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module pbr_bridge_arb_bench
  import pbr_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, park_gnt = 1'b0, s_gnt_l = 1'b1;
  logic s_frame_l = 1'b1, s_irdy_l = 1'b1;
  logic p_xfer_pending = 1'b0, p_xfer_done = 1'b0;
  logic s_mst_addr_ph = 1'b0, s_mst_wr_ph = 1'b0, s_mst_rd_ph = 1'b0, s_tgt_rd_ph = 1'b0;
  logic [3:0]       gnt_delay = 4'h0, busy_cyc = 4'h0;
  logic [SE_W-1:0]  ev = '0, serr_cause_en = '0;
  logic [AD_W-1:0]  s_mst_addr = '0, s_mst_wdata = '0, s_tgt_rdata = '0;
  logic [CBE_W-1:0] s_mst_cbe_l = 4'hf;
  logic p_gnt_l, p_frame_l, p_irdy_l, p_req_l_o, p_req_l_oe, p_serr_l_o, p_serr_l_oe;
  logic p_ad_oe, p_cbe_l_oe, p_par_o, p_par_oe, s_ad_oe, s_cbe_l_oe, s_par_o, s_par_oe;
  logic p_xfer_start;
  logic [AD_W-1:0]  p_ad_o, s_ad_o;
  logic [CBE_W-1:0] p_cbe_l_o, s_cbe_l_o;
  int n_fail = 0, checked = 0, cyc = 0;
  // Pull-ups on the shared lines
  wire p_serr_l = p_serr_l_oe ? p_serr_l_o : 1'b1;
  wire p_req_l  = p_req_l_oe ? p_req_l_o : 1'b1;

  always #50 sys_clk = ~sys_clk;

  pbr_bus_model i_pbr_bus_model (.sys_clk(sys_clk), .rst(rst), .p_req_l(p_req_l),
    .park_gnt(park_gnt), .gnt_delay(gnt_delay), .busy_cyc(busy_cyc),
    .p_gnt_l(p_gnt_l), .p_frame_l(p_frame_l), .p_irdy_l(p_irdy_l));

  pbr_bridge_arb i_pbr_bridge_arb (.sys_clk(sys_clk), .rst(rst), .p_gnt_l(p_gnt_l),
    .p_frame_l(p_frame_l), .p_irdy_l(p_irdy_l), .p_req_l_o(p_req_l_o),
    .p_req_l_oe(p_req_l_oe), .p_serr_l_o(p_serr_l_o), .p_serr_l_oe(p_serr_l_oe),
    .p_ad_o(p_ad_o), .p_ad_oe(p_ad_oe), .p_cbe_l_o(p_cbe_l_o), .p_cbe_l_oe(p_cbe_l_oe),
    .p_par_o(p_par_o), .p_par_oe(p_par_oe), .s_gnt_l(s_gnt_l), .s_frame_l(s_frame_l),
    .s_irdy_l(s_irdy_l), .s_serr_l(~ev[SE_SSERR]), .s_ad_o(s_ad_o), .s_ad_oe(s_ad_oe),
    .s_cbe_l_o(s_cbe_l_o), .s_cbe_l_oe(s_cbe_l_oe), .s_par_o(s_par_o), .s_par_oe(s_par_oe),
    .p_xfer_pending(p_xfer_pending), .p_xfer_done(p_xfer_done), .p_xfer_start(p_xfer_start),
    .ev_addr_par(ev[SE_APAR]), .ev_pw_data_par(ev[SE_PWPAR]), .ev_pw_mabort(ev[SE_PW_MABT]),
    .ev_pw_tabort(ev[SE_PW_TABT]), .ev_pw_discard(ev[SE_PW_DISC]),
    .ev_dw_discard(ev[SE_DW_DISC]), .ev_dr_discard(ev[SE_DR_DISC]),
    .ev_dt_timeout(ev[SE_DT_TMO]), .serr_cause_en(serr_cause_en),
    .s_mst_addr_ph(s_mst_addr_ph), .s_mst_wr_ph(s_mst_wr_ph), .s_mst_rd_ph(s_mst_rd_ph),
    .s_tgt_rd_ph(s_tgt_rd_ph), .s_mst_addr(s_mst_addr), .s_mst_wdata(s_mst_wdata),
    .s_mst_cbe_l(s_mst_cbe_l), .s_tgt_rdata(s_tgt_rdata));

  task automatic conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Sync lag means start may not follow the grant pin by fewer than three edges
  task automatic t_request(input logic [3:0] dly, input logic [3:0] busy);
    int n;
    int idle_at;
    @(posedge sys_clk);
    gnt_delay <= dly;
    busy_cyc <= busy;
    p_xfer_pending <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("p_req_l_o", 1'b0, p_req_l_o)
    n = 0;
    idle_at = -1;
    while (p_xfer_start !== 1'b1 && n < 60) begin
      if (idle_at < 0 && p_gnt_l === 1'b0 && p_frame_l === 1'b1 && p_irdy_l === 1'b1) idle_at = n;
      `CHK("p_req_l_o held", 1'b0, p_req_l_o)
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("p_xfer_start", 1'b1, p_xfer_start)
    `CHK("start after idle grant", 1'b1, idle_at >= 0 && n - idle_at >= 3)
    `CHK("p_req_l_o at start", 1'b1, p_req_l_o)
    @(posedge sys_clk);
    p_xfer_pending <= 1'b0;
    p_xfer_done <= 1'b1;
    #1;
    `CHK("p_xfer_start pulse", 1'b0, p_xfer_start)
    @(posedge sys_clk);
    p_xfer_done <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("p_req_l_o idle", 1'b1, p_req_l_o)
  endtask : t_request

  task automatic t_park;
    @(posedge sys_clk);
    park_gnt <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("p_ad_oe", 1'b1, p_ad_oe)
    `CHK("p_ad_o", PARK_AD, p_ad_o)
    `CHK("p_cbe_l_oe", 1'b1, p_cbe_l_oe)
    `CHK("p_cbe_l_o", PARK_CBE, p_cbe_l_o)
    `CHK("p_par_oe", 1'b1, p_par_oe)
    `CHK("p_par_o", ^{PARK_AD, PARK_CBE}, p_par_o)
    @(posedge sys_clk);
    park_gnt <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("p_ad_oe off", 1'b0, p_ad_oe)
    `CHK("p_par_oe off", 1'b0, p_par_oe)
  endtask : t_park

  // Each cause alone, once enabled and once masked with every other cause enabled
  task automatic t_serr;
    int lag;
    for (int i = 0; i < SE_W; i++) begin
      lag = (i == SE_SSERR) ? 5 : 1;
      for (int on = 1; on >= 0; on--) begin
        @(posedge sys_clk);
        serr_cause_en <= on ? (9'h001 << i) : ~(9'h001 << i);
        ev <= 9'h001 << i;
        repeat (lag) @(posedge sys_clk);
        #1;
        `CHK("p_serr_l", on == 0, p_serr_l)
        @(posedge sys_clk);
        ev <= '0;
        repeat (lag + 2) @(posedge sys_clk);
        #1;
        `CHK("p_serr_l released", 1'b1, p_serr_l)
      end
    end
  endtask : t_serr

  // Kinds: 0 address, 1 master write, 2 master read, 3 target read
  task automatic t_sec(input int kind, input logic [31:0] d, input logic [3:0] c);
    @(posedge sys_clk);
    s_mst_addr_ph <= kind == 0;
    s_mst_wr_ph <= kind == 1;
    s_mst_rd_ph <= kind == 2;
    s_tgt_rd_ph <= kind == 3;
    s_mst_addr <= d;
    s_mst_wdata <= d;
    s_tgt_rdata <= d;
    s_mst_cbe_l <= c;
    @(posedge sys_clk);
    {s_mst_addr_ph, s_mst_wr_ph, s_mst_rd_ph, s_tgt_rd_ph} <= 4'h0;
    #1;
    `CHK("s_ad_oe", kind != 2, s_ad_oe)
    `CHK("s_cbe_l_oe", kind != 3, s_cbe_l_oe)
    if (kind != 2) `CHK("s_ad_o", d, s_ad_o)
    if (kind != 3) `CHK("s_cbe_l_o", c, s_cbe_l_o)
    @(posedge sys_clk);
    #1;
    `CHK("s_par_oe", kind != 2, s_par_oe)
    if (kind < 2) `CHK("s_par_o", ^{d, c}, s_par_o)
  endtask : t_sec

  task automatic t_spark;
    @(posedge sys_clk);
    s_gnt_l <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("s_ad_oe park", 1'b1, s_ad_oe)
    `CHK("s_ad_o park", PARK_AD, s_ad_o)
    `CHK("s_cbe_l_oe park", 1'b1, s_cbe_l_oe)
    `CHK("s_par_oe park", 1'b1, s_par_oe)
    `CHK("s_par_o park", ^{PARK_AD, PARK_CBE}, s_par_o)
    // Parking must yield while another agent owns the secondary bus
    @(posedge sys_clk);
    s_frame_l <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("s_ad_oe frame busy", 1'b0, s_ad_oe)
    @(posedge sys_clk);
    s_frame_l <= 1'b1;
    s_irdy_l <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("s_ad_oe irdy busy", 1'b0, s_ad_oe)
    @(posedge sys_clk);
    s_irdy_l <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("s_ad_oe idle again", 1'b1, s_ad_oe)
    @(posedge sys_clk);
    s_gnt_l <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("s_ad_oe unpark", 1'b0, s_ad_oe)
  endtask : t_spark

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK("p_req_l_oe reset", 1'b0, p_req_l_oe)
    `CHK("p_serr_l_oe reset", 1'b0, p_serr_l_oe)
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("p_req_l_oe", 1'b1, p_req_l_oe)
    `CHK("p_req_l_o", 1'b1, p_req_l_o)
    t_request(4'h0, 4'h0);
    t_request(4'h6, 4'h9);
    t_park();
    t_serr();
    for (int k = 0; k < 4; k++) t_sec(k, 32'ha5c3_0f01 << k, 4'h6 + 4'(k));
    t_spark();
    conclude();
  end
endmodule : pbr_bridge_arb_bench
